// *** hw/icl_pin_edge.sv ***
`timescale 1ns/1ps
module icl_pin_edge
    import icl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    output logic            level_o,
    output logic            event_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // two-stage synchroniser; only sync_q and its delayed copy prev_q feed logic
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;

    // edge qualification by the two-bit select
    always_comb
    begin
        unique case (edge_sel_i)
            EDGE_OFF:  event_o = 1'b0;
            EDGE_RISE: event_o = sync_q & ~prev_q;
            EDGE_FALL: event_o = ~sync_q & prev_q;
            EDGE_BOTH: event_o = sync_q ^ prev_q;
        endcase
    end

endmodule : icl_pin_edge

// *** hw/icl_pkg.sv ***
package icl_pkg;

    // register indices in the special purpose data space (one 8-bit word each)
    localparam logic [2:0] IDX_LOWVOLT_CONTROL   = 3'h0;
    localparam logic [2:0] IDX_PIN_EDGE_SELECT   = 3'h1;
    localparam logic [2:0] IDX_PRIMARY_IRQ_CTL_A = 3'h2;
    localparam logic [2:0] IDX_PRIMARY_IRQ_CTL_B = 3'h3;
    localparam logic [2:0] IDX_PRIMARY_IRQ_CTL_C = 3'h4;
    localparam logic [2:0] IDX_SHARED_IRQ_CTL_A  = 3'h5;
    localparam logic [2:0] IDX_SHARED_IRQ_CTL_B  = 3'h6;
    localparam int         NUM_REGS              = 7;

    // writable bits of each register, indexed as above
    localparam logic [7:0] WMASK_LOWVOLT   = 8'h1F;
    localparam logic [7:0] WMASK_EDGE      = 8'h0F;
    localparam logic [7:0] WMASK_PRIM_A    = 8'h7F;
    localparam logic [7:0] WMASK_PRIM_B    = 8'hFF;
    localparam logic [7:0] WMASK_PRIM_C    = 8'h22;
    localparam logic [7:0] WMASK_SHARED_A  = 8'hFF;
    localparam logic [7:0] WMASK_SHARED_B  = 8'h33;
    localparam logic [7:0] REG_RESET       = 8'h00;

    // lowvolt_control fields
    localparam int LV_THRESH_LSB   = 0;
    localparam int LV_BANDGAP_BIT  = 3;
    localparam int LV_ENABLE_BIT   = 4;
    localparam int LV_OUTFLAG_BIT  = 5;
    localparam logic [2:0] LV_THRESH_EXT_PIN = 3'h0;

    // pin_edge_select fields
    localparam int EDGE_A_LSB = 0;
    localparam int EDGE_B_LSB = 2;

    // edge select encoding
    localparam logic [1:0] EDGE_OFF     = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // primary_irq_ctl_a fields
    localparam int GIE_BIT        = 0;
    localparam int PIN_A_EN_BIT   = 1;
    localparam int PIN_B_EN_BIT   = 2;
    localparam int CONV_EN_BIT    = 3;
    localparam int PIN_A_FLAG_BIT = 4;
    localparam int PIN_B_FLAG_BIT = 5;
    localparam int CONV_FLAG_BIT  = 6;

    // primary_irq_ctl_b fields
    localparam int MF0_EN_BIT   = 0;
    localparam int MF1_EN_BIT   = 1;
    localparam int USIM_EN_BIT  = 2;
    localparam int TB0_EN_BIT   = 3;
    localparam int MF0_FLAG_BIT = 4;
    localparam int MF1_FLAG_BIT = 5;
    localparam int USIM_FLAG_BIT = 6;
    localparam int TB0_FLAG_BIT = 7;

    // primary_irq_ctl_c fields
    localparam int TB1_EN_BIT   = 1;
    localparam int TB1_FLAG_BIT = 5;

    // shared_irq_ctl_b fields
    localparam int LV_IRQ_EN_BIT   = 0;
    localparam int EE_IRQ_EN_BIT   = 1;
    localparam int LV_IRQ_FLAG_BIT = 4;
    localparam int EE_IRQ_FLAG_BIT = 5;

    // vectored sources, lowest number served first
    localparam logic [2:0] VEC_PIN_A = 3'h0;
    localparam logic [2:0] VEC_PIN_B = 3'h1;
    localparam logic [2:0] VEC_CONV  = 3'h2;
    localparam logic [2:0] VEC_MF0   = 3'h3;
    localparam logic [2:0] VEC_MF1   = 3'h4;
    localparam logic [2:0] VEC_USIM  = 3'h5;
    localparam logic [2:0] VEC_TB0   = 3'h6;
    localparam logic [2:0] VEC_TB1   = 3'h7;
    localparam int         NUM_VEC   = 8;

    // timing
    localparam int CLK_PERIOD_NS = 40;

endpackage : icl_pkg

// *** hw/icl_top.sv ***
`timescale 1ns/1ps
module icl_top
    import icl_pkg::*;
#(
    parameter int LV_IRQ_DELAY_NS = 18000
)
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [2:0] reg_idx_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       ext_pin_a_i,
    input  wire logic       ext_pin_b_i,
    input  wire logic       conv_done_i,
    input  wire logic       usim_event_i,
    input  wire logic       tb0_event_i,
    input  wire logic       tb1_event_i,
    input  wire logic [3:0] timer_match_i,
    input  wire logic       eeprom_event_i,
    input  wire logic       lowvolt_cmp_i,
    input  wire logic       lowvolt_reset_function_i,
    input  wire logic       sleep_i,
    input  wire logic       stack_full_i,
    input  wire logic       irq_ack_i,
    output logic            irq_req_o,
    output logic      [2:0] irq_vector_o,
    output logic            wake_o,
    output logic            lowvolt_enable_o,
    output logic            bandgap_out_enable_o,
    output logic      [2:0] lowvolt_threshold_sel_o,
    output logic            lowvolt_ext_sel_o
);
    localparam int LV_DELAY_CYC_RAW = (LV_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LV_DELAY_CYC     = (LV_DELAY_CYC_RAW < 1) ? 1 : LV_DELAY_CYC_RAW;
    localparam int LV_CNT_W         = $clog2(LV_DELAY_CYC + 1);
    localparam logic [LV_CNT_W-1:0] LV_CNT_MAX = LV_CNT_W'(LV_DELAY_CYC);

    localparam logic [7:0] WMASK [NUM_REGS] = '{WMASK_LOWVOLT, WMASK_EDGE, WMASK_PRIM_A,
                                                WMASK_PRIM_B, WMASK_PRIM_C, WMASK_SHARED_A,
                                                WMASK_SHARED_B};

    logic [7:0]          regs_q [NUM_REGS];
    logic [7:0]          set_vec [NUM_REGS];
    logic [7:0]          clr_vec [NUM_REGS];
    logic [1:0]          pin_event;
    logic [2:0]          pin_settle_q;
    logic                lv_cmp_sync;
    logic                lv_out_q;
    logic [LV_CNT_W-1:0] lv_cnt_q;
    logic                lv_armed_q;
    logic                lv_fire;
    logic [NUM_VEC-1:0]  pend;
    logic                any_pend;
    logic [2:0]          pick;
    logic                mf0_set;
    logic                mf1_set;
    logic [7:0]          prim_a;
    logic [7:0]          prim_b;
    logic [7:0]          prim_c;
    logic [7:0]          sh_b;
    logic [7:0]          lv_ctl;
    logic                lv_active;

    assign lv_ctl = regs_q[IDX_LOWVOLT_CONTROL];
    assign prim_a = regs_q[IDX_PRIMARY_IRQ_CTL_A];
    assign prim_b = regs_q[IDX_PRIMARY_IRQ_CTL_B];
    assign prim_c = regs_q[IDX_PRIMARY_IRQ_CTL_C];
    assign sh_b   = regs_q[IDX_SHARED_IRQ_CTL_B];

    // detector runs only when enabled and not asleep
    assign lv_active = lv_ctl[LV_ENABLE_BIT] & ~sleep_i;

    // external pins, synchronised and edge qualified
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++)
        begin : g_pin
            icl_pin_edge u_edge (
                .clk_i      (clk_i),
                .sys_rst_i  (sys_rst_i),
                .pin_i      ((gp == 0) ? ext_pin_a_i : ext_pin_b_i),
                .edge_sel_i (regs_q[IDX_PIN_EDGE_SELECT][2*gp +: 2]),
                .level_o    (),
                .event_o    (pin_event[gp])
            );
        end
    endgenerate

    // pins idle high behind pull-ups, so reset would fake a rising edge;
    // edges count only once synchroniser and edge stage hold real levels
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            pin_settle_q <= 3'h0;
        else
            pin_settle_q <= {pin_settle_q[1:0], 1'b1};
    end

    // comparator level crosses in through the same synchroniser, edges unused
    icl_pin_edge u_lv_sync (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .pin_i      (lowvolt_cmp_i),
        .edge_sel_i (EDGE_OFF),
        .level_o    (lv_cmp_sync),
        .event_o    ()
    );

    // output flag follows the comparator while active, reads low when off
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            lv_out_q <= 1'b0;
        else
            lv_out_q <= lv_active & lv_cmp_sync;
    end

    // delay counter restarts on every drop so chatter cannot fire early
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            lv_cnt_q   <= '0;
            lv_armed_q <= 1'b1;
        end
        else if (!lv_out_q)
        begin
            lv_cnt_q   <= '0;
            lv_armed_q <= 1'b1;
        end
        else if (lv_armed_q)
        begin
            if (lv_cnt_q == LV_CNT_MAX - 1'b1)
                lv_armed_q <= 1'b0; // one flag per low-voltage episode
            lv_cnt_q <= lv_cnt_q + 1'b1;
        end
    end

    assign lv_fire = lv_armed_q & lv_out_q & (lv_cnt_q == LV_CNT_MAX - 1'b1);

    // multi-function summaries: any enabled sub-source sets the shared flag
    assign mf0_set = |(regs_q[IDX_SHARED_IRQ_CTL_A][7:4] & regs_q[IDX_SHARED_IRQ_CTL_A][3:0]);
    assign mf1_set = |(sh_b[5:4] & sh_b[1:0]);

    // hardware set and acknowledge clear per register
    always_comb
    begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
            set_vec[i] = 8'h00;
            clr_vec[i] = 8'h00;
        end
        set_vec[IDX_PRIMARY_IRQ_CTL_A][PIN_A_FLAG_BIT] = pin_event[0] & pin_settle_q[2];
        set_vec[IDX_PRIMARY_IRQ_CTL_A][PIN_B_FLAG_BIT] = pin_event[1] & pin_settle_q[2];
        set_vec[IDX_PRIMARY_IRQ_CTL_A][CONV_FLAG_BIT]  = conv_done_i;
        set_vec[IDX_PRIMARY_IRQ_CTL_B][MF0_FLAG_BIT]   = mf0_set;
        set_vec[IDX_PRIMARY_IRQ_CTL_B][MF1_FLAG_BIT]   = mf1_set;
        set_vec[IDX_PRIMARY_IRQ_CTL_B][USIM_FLAG_BIT]  = usim_event_i;
        set_vec[IDX_PRIMARY_IRQ_CTL_B][TB0_FLAG_BIT]   = tb0_event_i;
        set_vec[IDX_PRIMARY_IRQ_CTL_C][TB1_FLAG_BIT]   = tb1_event_i;
        set_vec[IDX_SHARED_IRQ_CTL_A][7:4]             = timer_match_i;
        set_vec[IDX_SHARED_IRQ_CTL_B][EE_IRQ_FLAG_BIT] = eeprom_event_i;
        set_vec[IDX_SHARED_IRQ_CTL_B][LV_IRQ_FLAG_BIT] = lv_fire;
        if (irq_ack_i)
        begin
            clr_vec[IDX_PRIMARY_IRQ_CTL_A][GIE_BIT] = 1'b1;
            unique case (irq_vector_o)
                VEC_PIN_A: clr_vec[IDX_PRIMARY_IRQ_CTL_A][PIN_A_FLAG_BIT] = 1'b1;
                VEC_PIN_B: clr_vec[IDX_PRIMARY_IRQ_CTL_A][PIN_B_FLAG_BIT] = 1'b1;
                VEC_CONV:  clr_vec[IDX_PRIMARY_IRQ_CTL_A][CONV_FLAG_BIT]  = 1'b1;
                VEC_MF0:   clr_vec[IDX_PRIMARY_IRQ_CTL_B][MF0_FLAG_BIT]   = 1'b1;
                VEC_MF1:   clr_vec[IDX_PRIMARY_IRQ_CTL_B][MF1_FLAG_BIT]   = 1'b1;
                VEC_USIM:  clr_vec[IDX_PRIMARY_IRQ_CTL_B][USIM_FLAG_BIT]  = 1'b1;
                VEC_TB0:   clr_vec[IDX_PRIMARY_IRQ_CTL_B][TB0_FLAG_BIT]   = 1'b1;
                VEC_TB1:   clr_vec[IDX_PRIMARY_IRQ_CTL_C][TB1_FLAG_BIT]   = 1'b1;
            endcase
        end
    end

    // register file: software write, then ack clear, then hardware set wins
    genvar gr;
    generate
        for (gr = 0; gr < NUM_REGS; gr++)
        begin : g_reg
            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                    regs_q[gr] <= REG_RESET;
                else if (reg_wr_i && reg_idx_i == 3'(gr))
                    regs_q[gr] <= ((reg_wdata_i & ~clr_vec[gr]) | set_vec[gr]) & WMASK[gr];
                else
                    regs_q[gr] <= ((regs_q[gr] & ~clr_vec[gr]) | set_vec[gr]) & WMASK[gr];
            end
        end
    endgenerate

    // pending vectored sources: flag and its enable
    assign pend[VEC_PIN_A] = prim_a[PIN_A_FLAG_BIT] & prim_a[PIN_A_EN_BIT];
    assign pend[VEC_PIN_B] = prim_a[PIN_B_FLAG_BIT] & prim_a[PIN_B_EN_BIT];
    assign pend[VEC_CONV]  = prim_a[CONV_FLAG_BIT]  & prim_a[CONV_EN_BIT];
    assign pend[VEC_MF0]   = prim_b[MF0_FLAG_BIT]   & prim_b[MF0_EN_BIT];
    assign pend[VEC_MF1]   = prim_b[MF1_FLAG_BIT]   & prim_b[MF1_EN_BIT];
    assign pend[VEC_USIM]  = prim_b[USIM_FLAG_BIT]  & prim_b[USIM_EN_BIT];
    assign pend[VEC_TB0]   = prim_b[TB0_FLAG_BIT]   & prim_b[TB0_EN_BIT];
    assign pend[VEC_TB1]   = prim_c[TB1_FLAG_BIT]   & prim_c[TB1_EN_BIT];
    assign any_pend        = |pend;

    // lowest pending number is offered first
    always_comb
    begin
        pick = 3'h0;
        for (int v = NUM_VEC - 1; v >= 0; v--)
        begin
            if (pend[v])
                pick = 3'(v);
        end
    end

    // request gated by global enable; dropped the cycle after an ack
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= 3'h0;
        end
        else
        begin
            irq_req_o    <= any_pend & prim_a[GIE_BIT] & ~stack_full_i & ~irq_ack_i;
            irq_vector_o <= pick;
        end
    end

    // any set flag wakes the core, enabled or not
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            wake_o <= 1'b0;
        else
            wake_o <= |{prim_a[6:4], prim_b[7:4], prim_c[TB1_FLAG_BIT],
                        regs_q[IDX_SHARED_IRQ_CTL_A][7:4], sh_b[5:4]};
    end

    // analog-side controls
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            lowvolt_enable_o        <= 1'b0;
            bandgap_out_enable_o    <= 1'b0;
            lowvolt_threshold_sel_o <= 3'h0;
            lowvolt_ext_sel_o       <= 1'b0;
        end
        else
        begin
            lowvolt_enable_o        <= lv_active;
            bandgap_out_enable_o    <= lv_ctl[LV_BANDGAP_BIT] | lv_active
                                       | lowvolt_reset_function_i;
            lowvolt_threshold_sel_o <= lv_ctl[LV_THRESH_LSB +: 3];
            lowvolt_ext_sel_o       <= lv_ctl[LV_THRESH_LSB +: 3] == LV_THRESH_EXT_PIN;
        end
    end

    // read data one cycle after the index; unimplemented bits read zero
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_idx_i == IDX_LOWVOLT_CONTROL)
            reg_rdata_o <= {2'b00, lv_out_q, lv_ctl[4:0]};
        else if (reg_idx_i < 3'(NUM_REGS))
            reg_rdata_o <= regs_q[reg_idx_i];
        else
            reg_rdata_o <= 8'h00;
    end

endmodule : icl_top

// *** tb/icl_core_model.sv ***
`timescale 1ns/1ps
module icl_core_model
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       irq_req_i,
    input  wire logic [2:0] irq_vector_i,
    input  wire logic       ack_en_i,
    input  wire logic [3:0] delay_i,
    output logic            irq_ack_o,
    output logic      [2:0] last_vec_o,
    output logic      [7:0] taken_o
);
    logic [3:0] wait_q;

    // takes a request after delay_i cycles; one pulse only, since the
    // request drops the cycle after the ack and must not be taken twice
    always_ff @(posedge clk_i)
    begin
        irq_ack_o <= 1'b0;
        wait_q <= 4'h0;
        if (sys_rst_i)
        begin
            last_vec_o <= 3'h0;
            taken_o <= 8'h00;
        end
        else if (irq_req_i && ack_en_i && !irq_ack_o)
        begin
            if (wait_q == delay_i)
            begin
                irq_ack_o <= 1'b1;
                last_vec_o <= irq_vector_i;
                taken_o <= taken_o + 8'h01;
            end
            else
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule : icl_core_model

// *** tb/icl_top_checker.sv ***
`timescale 1ns/1ps
module icl_top_checker
    import icl_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] reg_idx_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       lowvolt_reset_function_i,
    input wire logic       sleep_i,
    input wire logic       stack_full_i,
    input wire logic       irq_ack_i,
    input wire logic       irq_req_o,
    input wire logic       wake_o,
    input wire logic       lowvolt_enable_o,
    input wire logic       bandgap_out_enable_o,
    input wire logic [2:0] lowvolt_threshold_sel_o,
    input wire logic       lowvolt_ext_sel_o
);
    logic [4:0] lv_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // shadow of the writable detector bits, so outputs tie back to the write
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            lv_q <= 5'h00;
        else if (reg_wr_i && reg_idx_i == IDX_LOWVOLT_CONTROL)
            lv_q <= reg_wdata_i[4:0];
    end

    a_ack_drops_req: assert property (
        irq_ack_i |=> !irq_req_o)
        else $error("request held after ack");
    a_stack_blocks: assert property (
        stack_full_i |=> !irq_req_o)
        else $error("request with stack full");
    a_req_wakes: assert property (
        irq_req_o |-> wake_o)
        else $error("request without wake");
    a_det_enable: assert property (
        1'b1 |=> lowvolt_enable_o == ($past(lv_q[4]) && !$past(sleep_i)))
        else $error("detector enable mismatch");
    a_sleep_det_off: assert property (
        sleep_i [*2] |-> !lowvolt_enable_o)
        else $error("detector on in sleep");
    a_ext_sel_code: assert property (
        lowvolt_ext_sel_o |-> lowvolt_threshold_sel_o == 3'h0)
        else $error("external input with nonzero code");
    a_bandgap_on: assert property (
        (lv_q[3] || lowvolt_reset_function_i) |=> bandgap_out_enable_o)
        else $error("bandgap off");
    a_edge_hi_zero: assert property (
        $past(reg_idx_i) == IDX_PIN_EDGE_SELECT |-> reg_rdata_o[7:4] == 4'h0)
        else $error("edge register high bits set");
    a_lv_hi_zero: assert property (
        $past(reg_idx_i) == IDX_LOWVOLT_CONTROL |-> reg_rdata_o[7:6] == 2'h0)
        else $error("detector register high bits set");
endmodule : icl_top_checker

bind icl_top icl_top_checker u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_idx_i(reg_idx_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .sleep_i(sleep_i),
    .lowvolt_reset_function_i(lowvolt_reset_function_i), .stack_full_i(stack_full_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .wake_o(wake_o),
    .lowvolt_enable_o(lowvolt_enable_o), .bandgap_out_enable_o(bandgap_out_enable_o),
    .lowvolt_threshold_sel_o(lowvolt_threshold_sel_o), .lowvolt_ext_sel_o(lowvolt_ext_sel_o));

// *** tb/test_irq_control_with_lowvolt_source.sv ***
`timescale 1ns/1ps
module test_irq_control_with_lowvolt_source
    import icl_pkg::*;
;
    logic       clk_i       = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic [2:0] reg_idx_i   = 3'h0;
    logic       reg_wr_i    = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [1:0] pins        = 2'h0;
    logic       conv_done   = 1'b0;
    logic       lv_cmp      = 1'b0;
    logic [3:0] tmr_match   = 4'h0;
    logic       ee_evt      = 1'b0;
    logic       lvr_fn      = 1'b0;
    logic       sleep       = 1'b0;
    logic       stack_full  = 1'b0;
    logic       ack_en      = 1'b0;
    logic [3:0] core_dly    = 4'h0;
    logic       irq_ack, irq_req, wake, lv_en, bg_en, ext_sel;
    logic [2:0] irq_vec, thr_sel, last_vec;
    logic [7:0] reg_rdata_o, taken;
    int         err_total    = 0;
    int         total_checks = 0;
    // readable bits after writing all ones; index 7 is unmapped
    logic [7:0] wmask [8] = '{WMASK_LOWVOLT, WMASK_EDGE, WMASK_PRIM_A, WMASK_PRIM_B,
                              WMASK_PRIM_C, WMASK_SHARED_A, WMASK_SHARED_B, 8'h00};
    // interrupt cases: control word written and the vector it must reach
    logic [7:0] isr_wr  [3] = '{8'h13, 8'h25, 8'h09};
    logic [2:0] isr_vec [3] = '{VEC_PIN_A, VEC_PIN_B, VEC_CONV};

    // free-running system clock
    initial
    begin
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end

    icl_top #(.LV_IRQ_DELAY_NS(200)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_idx_i(reg_idx_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ext_pin_a_i(pins[0]),
        .ext_pin_b_i(pins[1]), .conv_done_i(conv_done), .usim_event_i(1'b0),
        .tb0_event_i(1'b0), .tb1_event_i(1'b0), .timer_match_i(tmr_match),
        .eeprom_event_i(ee_evt), .lowvolt_cmp_i(lv_cmp), .lowvolt_reset_function_i(lvr_fn),
        .sleep_i(sleep), .stack_full_i(stack_full), .irq_ack_i(irq_ack),
        .irq_req_o(irq_req), .irq_vector_o(irq_vec), .wake_o(wake), .lowvolt_enable_o(lv_en),
        .bandgap_out_enable_o(bg_en), .lowvolt_threshold_sel_o(thr_sel),
        .lowvolt_ext_sel_o(ext_sel));

    icl_core_model u_core (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .irq_req_i(irq_req), .irq_vector_i(irq_vec),
        .ack_en_i(ack_en), .delay_i(core_dly), .irq_ack_o(irq_ack), .last_vec_o(last_vec),
        .taken_o(taken));

    // every task starts and ends just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // strobe dropped a cycle before the next write so it never toggles in one step
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        reg_idx_i = idx;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
        reg_idx_i = idx;
        step(1);
        chk(reg_rdata_o, exp);
    endtask : rd

    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // bounded wait for the core to take interrupt number n
    task automatic wait_taken(input logic [7:0] n);
        int k;
        for (k = 0; k < 40 && taken !== n; k++)
            step(1);
        if (taken !== n)
        begin
            err_total++;
            $display("[ERR] %0t interrupt not taken", $time);
            print_verdict();
        end
    endtask : wait_taken

    initial
    begin
        int i;
        int p;
        int c;
        step(3);
        sys_rst_i = 1'b0;
        for (i = 0; i < 8; i++)
            rd(3'(i), REG_RESET);
        // all ones, then clear shared registers before the primary ones
        for (i = 0; i < 8; i++)
        begin
            wr(3'(i), 8'hFF);
            rd(3'(i), wmask[i]);
        end
        for (i = 6; i >= 0; i--)
            wr(3'(i), 8'h00);
        rd(IDX_PRIMARY_IRQ_CTL_B, 8'h00);
        // every edge code on both pins, rising then falling
        for (p = 0; p < 2; p++)
            for (c = 0; c < 4; c++)
            begin
                wr(IDX_PIN_EDGE_SELECT, 8'(c << (2 * p)));
                wr(IDX_PRIMARY_IRQ_CTL_A, 8'h00);
                pins[p] = 1'b1;
                step(5);
                rd(IDX_PRIMARY_IRQ_CTL_A, 8'(c[0]) << (4 + p));
                wr(IDX_PRIMARY_IRQ_CTL_A, 8'h00);
                pins[p] = 1'b0;
                step(5);
                rd(IDX_PRIMARY_IRQ_CTL_A, 8'(c[1]) << (4 + p));
            end
        // vectored interrupts, held off by a full stack, prompt and slow core
        ack_en = 1'b1;
        for (i = 0; i < 3; i++)
        begin
            stack_full = 1'b1;
            core_dly = 4'(3 * i);
            wr(IDX_PRIMARY_IRQ_CTL_A, isr_wr[i]);
            conv_done = (i == 2);
            step(1);
            conv_done = 1'b0;
            step(3);
            chk({7'h00, irq_req}, 8'h00);
            chk({7'h00, wake}, 8'h01);
            stack_full = 1'b0;
            wait_taken(8'(i + 1));
            chk({5'h00, last_vec}, {5'h00, isr_vec[i]});
            // the ack reaches the flags one edge after the core counts it
            step(1);
            rd(IDX_PRIMARY_IRQ_CTL_A, isr_wr[i] & 8'h0E);
        end
        // flag without enable, then enable without the global bit
        wr(IDX_PRIMARY_IRQ_CTL_A, 8'h21);
        step(4);
        rd(IDX_PRIMARY_IRQ_CTL_A, 8'h21);
        wr(IDX_PRIMARY_IRQ_CTL_A, 8'h24);
        step(4);
        rd(IDX_PRIMARY_IRQ_CTL_A, 8'h24);
        chk(taken, 8'h03);
        wr(IDX_PRIMARY_IRQ_CTL_A, 8'h00);
        // detector on at the lowest supply code
        wr(IDX_LOWVOLT_CONTROL, 8'h11);
        chk({lv_en, bg_en, ext_sel, 2'b00, thr_sel}, 8'hC1);
        // short low episodes must not set the detector irq flag
        for (i = 0; i < 4; i++)
        begin
            lv_cmp = ~lv_cmp;
            step(2);
        end
        step(4);
        rd(IDX_SHARED_IRQ_CTL_B, 8'h00);
        lv_cmp = 1'b1;
        step(4);
        rd(IDX_LOWVOLT_CONTROL, 8'h31);
        step(8);
        rd(IDX_SHARED_IRQ_CTL_B, 8'h10);
        sleep = 1'b1;
        step(4);
        rd(IDX_LOWVOLT_CONTROL, 8'h11);
        chk({6'h00, lv_en, bg_en}, 8'h00);
        lvr_fn = 1'b1;
        step(2);
        chk({7'h00, bg_en}, 8'h01);
        sleep = 1'b0;
        lvr_fn = 1'b0;
        lv_cmp = 1'b0;
        // code 000 selects the external input; bandgap by its own bit
        wr(IDX_LOWVOLT_CONTROL, 8'h08);
        chk({lv_en, bg_en, ext_sel, 2'b00, thr_sel}, 8'h60);
        // shared sources roll up into the multi-function flags
        wr(IDX_SHARED_IRQ_CTL_A, 8'h01);
        tmr_match = 4'h1;
        step(1);
        tmr_match = 4'h0;
        rd(IDX_SHARED_IRQ_CTL_A, 8'h11);
        rd(IDX_PRIMARY_IRQ_CTL_B, 8'h10);
        wr(IDX_SHARED_IRQ_CTL_B, 8'h02);
        ee_evt = 1'b1;
        step(1);
        ee_evt = 1'b0;
        rd(IDX_SHARED_IRQ_CTL_B, 8'h22);
        rd(IDX_PRIMARY_IRQ_CTL_B, 8'h30);
        print_verdict();
    end
endmodule : test_irq_control_with_lowvolt_source
